// >>> core/atx_defs.vh
// Constants for the pass-through command block executor
// ==========================================================
`ifndef ATX_DEFS_VH
`define ATX_DEFS_VH
// ==========================================================
// Register byte addresses
`define ATX_ADDR_CTRL 6'h00
`define ATX_ADDR_STATUS 6'h04
`define ATX_ADDR_SIG 6'h08
`define ATX_ADDR_FLAGS 6'h0C
`define ATX_ADDR_CB0 6'h10
`define ATX_ADDR_CB1 6'h14
`define ATX_ADDR_CB2 6'h18
`define ATX_ADDR_CB3 6'h1C
`define ATX_ADDR_RB0 6'h20
`define ATX_ADDR_RB1 6'h24
// ==========================================================
// Field positions
`define ATX_CTRL_START 0
`define ATX_CTRL_LUNDRV 1
`define ATX_ACT_IDENT 7
`define ATX_ACT_UDMA 6
`define ATX_ACT_DRVSRC 5
`define ATX_ACT_DERR 4
`define ATX_ACT_PERR 3
`define ATX_ACT_NOPOLL 2
`define ATX_ACT_LATE 1
`define ATX_ACT_RBONLY 0
`define ATX_FLAG_DIR 7
`define ATX_DEV_BIT 4
`define ATX_BSY_BIT 7
// ==========================================================
// Command block layout and codes
`define ATX_SUBCMD 8'h24
`define ATX_CB_SIG 4'h0
`define ATX_CB_SUB 4'h1
`define ATX_CB_ACT 4'h2
`define ATX_CB_MASK 4'h3
`define ATX_CB_COUNT 4'h4
`define ATX_CB_WR0 4'h5
`define ATX_TF_ALT 3'h0
`define ATX_TF_DEV 3'h6
`define ATX_TF_COUNT 4'h8
`define ATX_FULL_BLOCK 9'h100
`define ATX_SIG_RESET 8'h00
`define ATX_RESP_OK 2'h0
`define ATX_RESP_ERR 2'h2
`endif

// >>> core/atx_ata_block_executor.v
// Pass-through command block executor with AXI4-Lite register access
`timescale 1ns/100ps
`include "atx_defs.vh"
module atx_ata_block_executor (
  // Clock, reset, enable
  input wire refClk,
  input wire reset,
  input wire clkEn,
  // AXI4-Lite slave
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Task-file access port to the drive bus engine
  output reg taskReq,
  output reg taskWrite,
  output reg [2:0] taskIndex,
  output reg [7:0] taskWrData,
  input wire [7:0] taskRdData,
  input wire taskAck,
  // Data phase engine
  output reg xferStart,
  output reg xferUdma,
  output reg xferIdentify,
  output reg xferDirIn,
  output reg [8:0] xferBlocks,
  output reg xferAbort,
  input wire xferDone,
  input wire driveError,
  input wire phaseError,
  // Hand-off to the ordinary mass-storage path
  output reg ordinaryCmd
);

  // ==========================================================
  // Sequencer states
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_CHECK = 8'h02;
  localparam [7:0] S_POLL = 8'h04;
  localparam [7:0] S_EARLY = 8'h08;
  localparam [7:0] S_REGS = 8'h10;
  localparam [7:0] S_LATE = 8'h20;
  localparam [7:0] S_XFER = 8'h40;
  localparam [7:0] S_END = 8'h80;

  reg [7:0] state;
  reg [3:0] idx;
  reg [127:0] cmdBlock;
  reg [7:0] sigByte;
  reg [7:0] flagsByte;
  reg lunDrive;
  reg [63:0] readback;
  reg stBusy, stDone, stFail, stOrdinary, stDrvErr, stPhaseErr;
  reg startReq;
  reg [5:0] awAddr;
  reg awHeld, wHeld;
  reg [31:0] wData;
  reg [3:0] wStrb;

  // ==========================================================
  // Decoding helpers
  function [7:0] cbByte;
    input [127:0] blk;
    input [3:0] n;
    begin
      cbByte = blk[{n, 3'h0} +: 8];
    end
  endfunction

  function [31:0] mergeWord;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      mergeWord = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          mergeWord[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  wire [7:0] actByte = cbByte(cmdBlock, `ATX_CB_ACT);
  wire [7:0] maskByte = cbByte(cmdBlock, `ATX_CB_MASK);
  wire [7:0] countByte = cbByte(cmdBlock, `ATX_CB_COUNT);
  wire rbOnly = actByte[`ATX_ACT_RBONLY];
  wire lateSel = actByte[`ATX_ACT_LATE];
  // Zero or a single set bit: the only block sizes the data engine supports
  wire countLegal = (countByte & (countByte - 8'h01)) == 8'h00;
  wire sigOk = cbByte(cmdBlock, `ATX_CB_SIG) == sigByte;
  wire subOk = cbByte(cmdBlock, `ATX_CB_SUB) == `ATX_SUBCMD;

  // ==========================================================
  // Which task-file access the current state needs
  reg accNeed;
  reg [2:0] accIdx;
  reg [7:0] accData;
  reg [7:0] devByte;
  always @* begin
    accNeed = 1'b0;
    accIdx = idx[2:0];
    devByte = cbByte(cmdBlock, `ATX_CB_WR0 + {1'b0, `ATX_TF_DEV});
    if (!actByte[`ATX_ACT_DRVSRC]) begin
      devByte[`ATX_DEV_BIT] = lunDrive;
    end
    case (state)
      S_POLL: begin
        accNeed = 1'b1;
        accIdx = `ATX_TF_ALT;
      end
      S_EARLY: begin
        accNeed = !rbOnly && !lateSel && maskByte[`ATX_TF_DEV];
        accIdx = `ATX_TF_DEV;
      end
      S_REGS: begin
        // Device register is handled by the early or late step on writes
        accNeed = !idx[3] && maskByte[idx[2:0]] && (rbOnly || idx[2:0] != `ATX_TF_DEV);
      end
      S_LATE: begin
        accNeed = !rbOnly && lateSel && maskByte[`ATX_TF_DEV];
        accIdx = `ATX_TF_DEV;
      end
      default: begin
        accNeed = 1'b0;
      end
    endcase
    if (accIdx == `ATX_TF_DEV) begin
      accData = devByte;
    end else begin
      accData = cbByte(cmdBlock, `ATX_CB_WR0 + {1'b0, accIdx});
    end
  end

  wire accState = (state == S_POLL) || (state == S_EARLY) || (state == S_REGS) || (state == S_LATE);
  wire stepDone = accState && (!accNeed || (taskReq && taskAck));

  // ==========================================================
  // Sequencer
  always @(posedge refClk) begin
    if (reset) begin
      state <= S_IDLE;
      idx <= 4'h0;
      taskReq <= 1'b0;
      taskWrite <= 1'b0;
      taskIndex <= 3'h0;
      taskWrData <= 8'h00;
      xferStart <= 1'b0;
      xferUdma <= 1'b0;
      xferIdentify <= 1'b0;
      xferDirIn <= 1'b0;
      xferBlocks <= 9'h000;
      xferAbort <= 1'b0;
      ordinaryCmd <= 1'b0;
      readback <= 64'h0;
      stBusy <= 1'b0;
      stDone <= 1'b0;
      stFail <= 1'b0;
      stOrdinary <= 1'b0;
      stDrvErr <= 1'b0;
      stPhaseErr <= 1'b0;
    end else if (clkEn) begin
      xferStart <= 1'b0;
      xferAbort <= 1'b0;
      ordinaryCmd <= 1'b0;
      if (accState && accNeed && !taskReq) begin
        taskReq <= 1'b1;
        taskWrite <= !rbOnly && state != S_POLL;
        taskIndex <= accIdx;
        taskWrData <= accData;
      end else if (taskReq && taskAck) begin
        taskReq <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (startReq) begin
            state <= S_CHECK;
            stBusy <= 1'b1;
            {stDone, stFail, stOrdinary, stDrvErr, stPhaseErr} <= 5'h00;
            readback <= 64'h0;
          end
        end
        S_CHECK: begin
          idx <= 4'h0;
          if (!(sigOk && subOk)) begin
            // Not ours: pass it on and stay out of the drive bus
            ordinaryCmd <= 1'b1;
            stOrdinary <= 1'b1;
            stBusy <= 1'b0;
            state <= S_IDLE;
          end else if (!countLegal) begin
            stFail <= 1'b1;
            state <= S_END;
          end else if (actByte[`ATX_ACT_NOPOLL]) begin
            state <= S_EARLY;
          end else begin
            state <= S_POLL;
          end
        end
        S_POLL: begin
          if (stepDone && !taskRdData[`ATX_BSY_BIT]) begin
            state <= S_EARLY;
          end
        end
        S_EARLY: begin
          if (stepDone) begin
            state <= S_REGS;
          end
        end
        S_REGS: begin
          if (idx[3]) begin
            state <= S_LATE;
          end else if (stepDone) begin
            if (rbOnly && accNeed) begin
              readback[{idx[2:0], 3'h0} +: 8] <= taskRdData;
            end
            idx <= idx + 4'h1;
          end
        end
        S_LATE: begin
          if (stepDone) begin
            if (rbOnly) begin
              state <= S_END;
            end else begin
              state <= S_XFER;
              xferStart <= 1'b1;
              xferUdma <= actByte[`ATX_ACT_UDMA];
              xferIdentify <= actByte[`ATX_ACT_IDENT];
              xferDirIn <= flagsByte[`ATX_FLAG_DIR];
              xferBlocks <= (countByte == 8'h00) ? `ATX_FULL_BLOCK : {1'b0, countByte};
            end
          end
        end
        S_XFER: begin
          if (driveError) begin
            stDrvErr <= 1'b1;
          end
          if (phaseError) begin
            stPhaseErr <= 1'b1;
          end
          if (xferDone) begin
            state <= S_END;
          end else if ((driveError && !actByte[`ATX_ACT_DERR])
                       || (phaseError && !actByte[`ATX_ACT_PERR])) begin
            xferAbort <= 1'b1;
            stFail <= 1'b1;
            state <= S_END;
          end
        end
        S_END: begin
          stBusy <= 1'b0;
          stDone <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  always @(posedge refClk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ATX_RESP_OK;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ATX_RESP_OK;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 6'h00;
      wData <= 32'h0;
      wStrb <= 4'h0;
      cmdBlock <= 128'h0;
      sigByte <= `ATX_SIG_RESET;
      flagsByte <= 8'h00;
      lunDrive <= 1'b0;
      startReq <= 1'b0;
    end else if (clkEn) begin
      if (state == S_CHECK) begin
        startReq <= 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awHeld && wHeld && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ATX_RESP_OK;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        // Command block stays frozen while the sequencer reads it
        case ({awAddr[5:2], 2'b00})
          `ATX_ADDR_CTRL: begin
            if (wStrb[0]) begin
              lunDrive <= wData[`ATX_CTRL_LUNDRV];
              if (wData[`ATX_CTRL_START] && !stBusy) begin
                startReq <= 1'b1;
              end
            end
          end
          `ATX_ADDR_STATUS: begin
            s_axi_bresp <= `ATX_RESP_OK;
          end
          `ATX_ADDR_SIG: begin
            if (wStrb[0]) begin
              sigByte <= wData[7:0];
            end
          end
          `ATX_ADDR_FLAGS: begin
            if (wStrb[0]) begin
              flagsByte <= wData[7:0];
            end
          end
          `ATX_ADDR_CB0, `ATX_ADDR_CB1, `ATX_ADDR_CB2, `ATX_ADDR_CB3: begin
            if (!stBusy) begin
              cmdBlock[{awAddr[3:2], 5'h00} +: 32] <= mergeWord(cmdBlock[{awAddr[3:2], 5'h00} +: 32], wData, wStrb);
            end
          end
          `ATX_ADDR_RB0, `ATX_ADDR_RB1: begin
            s_axi_bresp <= `ATX_RESP_OK;
          end
          default: begin
            s_axi_bresp <= `ATX_RESP_ERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ATX_RESP_OK;
        case ({s_axi_araddr[5:2], 2'b00})
          `ATX_ADDR_CTRL: s_axi_rdata <= {30'h0, lunDrive, 1'b0};
          `ATX_ADDR_STATUS: s_axi_rdata <= {26'h0, stPhaseErr, stDrvErr, stOrdinary, stFail, stDone, stBusy};
          `ATX_ADDR_SIG: s_axi_rdata <= {24'h0, sigByte};
          `ATX_ADDR_FLAGS: s_axi_rdata <= {24'h0, flagsByte};
          `ATX_ADDR_CB0, `ATX_ADDR_CB1, `ATX_ADDR_CB2, `ATX_ADDR_CB3: begin
            s_axi_rdata <= cmdBlock[{s_axi_araddr[3:2], 5'h00} +: 32];
          end
          `ATX_ADDR_RB0: s_axi_rdata <= readback[31:0];
          `ATX_ADDR_RB1: s_axi_rdata <= readback[63:32];
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ATX_RESP_ERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // atx_ata_block_executor

// >>> test/atx_exec_asserts.sv
// Port-level assertions for the pass-through block executor
`timescale 1ns/100ps
module atx_exec_asserts (
  // Clock and reset
  input wire refClk,
  input wire reset,
  // Task-file port
  input wire taskReq,
  input wire taskWrite,
  input wire [2:0] taskIndex,
  input wire taskAck,
  // Data phase and hand-off
  input wire xferStart,
  input wire [8:0] xferBlocks,
  input wire xferAbort,
  input wire driveError,
  input wire phaseError,
  input wire ordinaryCmd
);
  // ====
  // Properties
  default clocking @(posedge refClk); endclocking
  default disable iff (reset);
  chk_req_hold: assert property (taskReq && !taskAck |=> taskReq && $stable(taskIndex) && $stable(taskWrite))
    else $error("task request changed before acknowledge");
  chk_req_release: assert property (taskReq && taskAck |=> !taskReq)
    else $error("task request held after acknowledge");
  chk_ord_quiet: assert property (ordinaryCmd |-> !taskReq [*5])
    else $error("drive access after hand-off");
  chk_ord_pulse: assert property (ordinaryCmd |=> !ordinaryCmd && !xferStart)
    else $error("hand-off not a single pulse");
  chk_start_pulse: assert property (xferStart |=> !xferStart)
    else $error("start pulse too long");
  chk_blocks_legal: assert property (xferStart |=> $onehot(xferBlocks))
    else $error("illegal block count at start");
  // Count may only move with a start, or a running phase would see it change
  chk_blocks_hold: assert property (!xferStart |-> $stable(xferBlocks))
    else $error("block count changed outside start");
  chk_abort_cause: assert property (xferAbort |-> $past(driveError) || $past(phaseError) ||
    $past(driveError, 2) || $past(phaseError, 2))
    else $error("abort without error");
  chk_abort_pulse: assert property (xferAbort |=> !xferAbort && !xferStart)
    else $error("abort not a single pulse");
  cover property (xferStart);
  cover property (xferAbort);
  cover property (ordinaryCmd);
endmodule // atx_exec_asserts
bind atx_ata_block_executor atx_exec_asserts atx_exec_asserts_inst (.refClk(refClk), .reset(reset),
  .taskReq(taskReq), .taskWrite(taskWrite), .taskIndex(taskIndex), .taskAck(taskAck),
  .xferStart(xferStart), .xferBlocks(xferBlocks), .xferAbort(xferAbort),
  .driveError(driveError), .phaseError(phaseError), .ordinaryCmd(ordinaryCmd));

// >>> test/atx_drive_model.sv
// Behavioural drive answering task-file accesses and data phases
`timescale 1ns/100ps
module atx_drive_model #(parameter int BUSY_READS = 2) (
  // Clock and reset
  input wire refClk,
  input wire reset,
  // Answer latency
  input wire [1:0] lat,
  // Task-file port
  input wire taskReq,
  input wire taskWrite,
  input wire [2:0] taskIndex,
  input wire [7:0] taskWrData,
  output reg [7:0] taskRdData,
  output reg taskAck,
  // Data phase
  input wire xferStart,
  input wire xferAbort,
  output reg xferDone
);
  // ====
  // Registers and responder
  reg [7:0] tf [0:7];
  reg [1:0] wcnt;
  reg [2:0] bsy;
  reg [3:0] xc;
  always @(posedge refClk) begin
    taskAck <= 1'b0;
    xferDone <= 1'b0;
    // Read lines toggle when idle so a stray sample never matches
    taskRdData <= ~taskRdData;
    if (reset) begin
      taskRdData <= 8'h5A;
      wcnt <= 2'h0;
      bsy <= 3'(BUSY_READS);
      xc <= 4'h0;
      for (int i = 0; i < 8; i++) tf[i] <= 8'(8'h10 + i);
    end else begin
      if (taskReq && !taskAck) begin
        wcnt <= wcnt + 2'h1;
        if (wcnt == lat) begin
          wcnt <= 2'h0;
          taskAck <= 1'b1;
          if (taskWrite) begin
            tf[taskIndex] <= taskWrData;
            bsy <= 3'(BUSY_READS);
          end else if (taskIndex == 3'h0 && bsy != 3'h0) begin
            taskRdData <= 8'hD0;
            bsy <= bsy - 3'h1;
          end else begin
            taskRdData <= (taskIndex == 3'h0 || taskIndex == 3'h7) ? 8'h50 : tf[taskIndex];
          end
        end
      end
      if (xferStart) xc <= 4'h8;
      else if (xferAbort) xc <= 4'h0;
      else if (xc != 4'h0) begin
        xc <= xc - 4'h1;
        xferDone <= (xc == 4'h1);
      end
    end
  end
endmodule // atx_drive_model

// >>> test/tb_top.sv
// Self-checking bench for the pass-through block executor
`timescale 1ns/100ps
`include "atx_defs.vh"
module tb_top;
  // ====
  // Signals
  localparam int BUSY_READS = 2;
  localparam logic [7:0] SIG = 8'hA5; // Arbitrary signature value
  reg refClk = 1'b0, reset = 1'b1, clkEn = 1'b1;
  reg [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire taskReq, taskWrite, taskAck, xferStart, xferUdma, xferIdentify, xferDirIn, xferAbort, xferDone, ordinaryCmd;
  wire [2:0] taskIndex;
  wire [7:0] taskWrData, taskRdData;
  wire [8:0] xferBlocks;
  reg driveError = 1'b0, phaseError = 1'b0, injD = 1'b0, injP = 1'b0;
  reg [1:0] lat = 2'h0;
  int seed = 87, mismatches = 0, compares = 0, nStart, nAbort, nOrd, bsyLeft = BUSY_READS;
  logic [11:0] got[$], exp[$], xf;
  logic [7:0] cb [0:15], tf [0:7], rv;
  logic [63:0] rbE;
  logic [31:0] rd;
  logic [1:0] resp;
  atx_ata_block_executor atx_ata_block_executor_inst (.*);
  atx_drive_model #(.BUSY_READS(BUSY_READS)) atx_drive_model_inst (.*);
  always #12.5 refClk = ~refClk;
  // ====
  // Monitor and error injection
  always @(posedge refClk) begin
    if (taskReq === 1'b1 && taskAck === 1'b1) got.push_back({taskWrite, taskIndex, taskWrite ? taskWrData : taskRdData});
    if (xferStart === 1'b1) begin
      nStart++;
      driveError <= injD;
      phaseError <= injP;
    end
    if (xferAbort === 1'b1) nAbort++;
    if (ordinaryCmd === 1'b1) nOrd++;
    if (xferDone === 1'b1 || xferAbort === 1'b1) begin
      xf = {xferUdma, xferIdentify, xferDirIn, xferBlocks};
      driveError <= 1'b0;
      phaseError <= 1'b0;
    end
  end
  // ====
  // Tasks
  task check(input logic [31:0] e, input logic [31:0] g, input string n);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_of_test;
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge refClk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge refClk);
      aw = s_axi_awvalid && s_axi_awready === 1'b1;
      w = s_axi_wvalid && s_axi_wready === 1'b1;
      b = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge refClk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask
  task axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, b;
    @(posedge refClk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge refClk);
      ar = s_axi_arvalid && s_axi_arready === 1'b1;
      b = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge refClk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (b) s_axi_rready <= 1'b0;
    end
  endtask
  task put(input logic w, input int i, input logic [7:0] d);
    exp.push_back({w, 3'(i), d});
    if (w) begin
      tf[i] = d;
      bsyLeft = BUSY_READS;
    end
  endtask
  task get(input int i);
    rv = (i == 0 && bsyLeft > 0) ? 8'hD0 : (i == 0 || i == 7) ? 8'h50 : tf[i];
    if (i == 0 && bsyLeft > 0) bsyLeft--;
    rbE[8*i +: 8] = rv;
    put(1'b0, i, rv);
  endtask
  task run_cmd(input int k);
    logic [7:0] a, dv, fl;
    logic drv;
    logic [3:0] est;
    int xs, ab;
    for (int i = 0; i < 16; i++) cb[i] = 8'($random(seed));
    cb[0] = (k == 1) ? ~SIG : SIG;
    cb[1] = (k == 2) ? 8'h26 : 8'h24;
    if (cb[2][0]) cb[2][4:3] = 2'b00;
    cb[4] = (k == 3) ? 8'h03 : (k == 4) ? 8'h00 : 8'h01 << cb[4][2:0];
    cb[12] = cb[2][7] ? 8'hEC : 8'h20;
    for (int i = 13; i < 16; i++) cb[i] = 8'h00;
    a = cb[2];
    fl = 8'($random(seed));
    drv = 1'($random(seed));
    injD <= 1'($random(seed));
    injP <= 1'($random(seed));
    lat <= 2'($random(seed));
    axw(`ATX_ADDR_FLAGS, {24'h0, fl}, resp);
    for (int i = 0; i < 4; i++) axw(`ATX_ADDR_CB0 + 6'(4*i), {cb[4*i+3], cb[4*i+2], cb[4*i+1], cb[4*i]}, resp);
    got.delete();
    exp.delete();
    rbE = 64'h0;
    nStart = 0;
    nAbort = 0;
    nOrd = 0;
    axw(`ATX_ADDR_CTRL, {30'h0, drv, 1'b1}, resp);
    repeat (3) @(posedge refClk);
    do axr(`ATX_ADDR_STATUS, rd, resp); while (rd[0] !== 1'b0);
    xs = 0;
    ab = 0;
    est = 4'h8;
    dv = a[5] ? cb[11] : {cb[11][7:5], drv, cb[11][3:0]};
    if (cb[0] == SIG && cb[1] == 8'h24) begin
      est = 4'h6;
      if (cb[4] == 8'h00 || $onehot(cb[4])) begin
        if (!a[2]) do get(0); while (rv[7]);
        // Poll answers are not part of the returned bytes
        rbE = 64'h0;
        if (!a[0] && !a[1] && cb[3][6]) put(1'b1, 6, dv);
        for (int i = 0; i < 8; i++) if (cb[3][i] && a[0]) get(i); else if (cb[3][i] && i != 6) put(1'b1, i, cb[5+i]);
        if (!a[0] && a[1] && cb[3][6]) put(1'b1, 6, dv);
        xs = !a[0];
        ab = xs && ((injD && !a[4]) || (injP && !a[3]));
        est = ab ? 4'h6 : 4'h2;
      end
    end
    check({26'h0, injP && xs != 0, injD && xs != 0, est}, rd, "status");
    check(exp.size(), got.size(), "accesses");
    foreach (exp[i]) check(exp[i], got[i], "access");
    check(xs, nStart, "starts");
    check(ab, nAbort, "aborts");
    check(est == 4'h8, nOrd, "handoff");
    if (xs) check({a[6], a[7], fl[7], cb[4] == 8'h00 ? 9'h100 : {1'b0, cb[4]}}, xf, "mode");
    if (a[0] && est == 4'h2) begin
      axr(`ATX_ADDR_RB0, rd, resp);
      check(rbE[31:0], rd, "readback0");
      axr(`ATX_ADDR_RB1, rd, resp);
      check(rbE[63:32], rd, "readback1");
    end
  endtask
  // ====
  // Main sequence
  initial begin
    for (int i = 0; i < 8; i++) tf[i] = 8'(8'h10 + i);
    repeat (4) @(posedge refClk);
    reset <= 1'b0;
    axr(`ATX_ADDR_SIG, rd, resp);
    check(32'h0, rd, "signature reset");
    axr(6'h28, rd, resp);
    check(2'h2, resp, "unmapped read");
    axw(6'h28, 32'h1, resp);
    check(2'h2, resp, "unmapped write");
    axw(`ATX_ADDR_SIG, {24'h0, SIG}, resp);
    // Enable low: a read offered now must wait untaken
    clkEn <= 1'b0;
    s_axi_araddr <= `ATX_ADDR_SIG;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (3) @(posedge refClk);
    check(32'h2, {s_axi_arready, s_axi_rvalid}, "frozen read");
    clkEn <= 1'b1;
    @(posedge refClk);
    s_axi_arvalid <= 1'b0;
    @(posedge refClk);
    s_axi_rready <= 1'b0;
    check({24'h1, SIG}, {23'h0, s_axi_rvalid, s_axi_rdata[7:0]}, "read after freeze");
    for (int k = 0; k < 24; k++) run_cmd(k);
    end_of_test;
  end
  // Hang guard, well beyond the expected run length
  initial begin
    #1000000;
    mismatches++;
    end_of_test;
  end
endmodule // tb_top
